// ==== hw/sspc_pkg.sv ====
// sspc_pkg: shared constants and types of the self sector programming controller
package sspc_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_ARRAY_SEL = 8'ha7;
  localparam logic [7:0] ADDR_TYPE = 8'hf2;
  localparam logic [7:0] ADDR_KEY1 = 8'hf3;
  localparam logic [7:0] ADDR_KEY2 = 8'hf4;
  localparam logic [7:0] ADDR_KEY3 = 8'hf5;
  localparam logic [7:0] ADDR_KEY4 = 8'hf6;
  localparam logic [7:0] ADDR_PAGE = 8'hf7;
  localparam logic [7:0] ADDR_OFFSET = 8'hfb;
  localparam logic [7:0] ADDR_DATA = 8'hfc;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PAGE = 6'h00;
  localparam logic [3:0] RST_KEY = 4'h0;
  localparam logic RST_ARRAY_SEL = 1'b0;

  // key values in the order they must be written
  localparam logic [3:0] KEY1_VAL = 4'h5;
  localparam logic [3:0] KEY2_VAL = 4'ha;
  localparam logic [3:0] KEY3_VAL = 4'h9;
  localparam logic [3:0] KEY4_VAL = 4'h6;
  localparam int NUM_KEYS = 4;

  // operation type codes
  localparam logic [7:0] TYPE_ERASE = 8'he6;
  localparam logic [7:0] TYPE_PROG = 8'h6e;

  // field layout
  localparam int ARRAY_SEL_POS = 0;
  localparam int PAGE_W = 6;
  localparam int KEY_W = 4;
  localparam int ADDR_W = 14;
  localparam int MAIN_SECT_LSB = 2;
  localparam int MAIN_SECT_MSB = 5;
  localparam int HIGH_ADDR_MSB = 1;
  localparam logic [9:0] MAIN_SECT_BASE = 10'h000;
  localparam logic [7:0] EE_SECT_BASE = 8'h00;
  localparam logic [3:0] EE_ADDR_PAD = 4'h0;
  localparam logic [7:0] BLANK_BYTE = 8'hff;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int ERASE_MAX_MS = 3;
  localparam int PROG_MAX_US = 30;
  localparam int ERASE_MAX_CYC = ERASE_MAX_MS * 1000 * CLK_MHZ;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
  localparam int TMO_W = 19;
  localparam int SETTLE_CYC = 4;

  // register decode result
  typedef enum logic [3:0] {
    REG_NONE, REG_ARRAY_SEL, REG_TYPE, REG_KEY1, REG_KEY2, REG_KEY3, REG_KEY4,
    REG_PAGE, REG_OFFSET, REG_DATA
  } sspc_reg_e;

endpackage : sspc_pkg

// ==== hw/sspc_op_if.sv ====
// sspc_op_if: operation request and result between sequencer and flash port
`timescale 1ns/1ns
interface sspc_op_if;
  logic start;
  logic erase;
  logic ee_sel;
  logic [13:0] addr;
  logic [7:0] wdata;
  logic done;
  logic refused;
  logic timeout;

  modport ctrl (output start, output erase, output ee_sel, output addr, output wdata,
                input done, input refused, input timeout);
  modport port (input start, input erase, input ee_sel, input addr, input wdata,
                output done, output refused, output timeout);
endinterface : sspc_op_if

// ==== hw/sspc_flash_port.sv ====
// sspc_flash_port: drives the flash array for one erase or one byte program
`timescale 1ns/1ns
module sspc_flash_port #(
  parameter logic [18:0] ERASE_CYC = 19'(sspc_pkg::ERASE_MAX_CYC),
  parameter logic [18:0] PROG_CYC = 19'(sspc_pkg::PROG_MAX_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  sspc_op_if.port op,
  output logic fl_rd_o,
  output logic fl_prog_o,
  output logic fl_erase_o,
  output logic fl_ee_sel_o,
  output logic [13:0] fl_addr_o,
  output logic [7:0] fl_wdata_o,
  input wire logic [7:0] fl_rdata_i,
  input wire logic fl_ack_i
);

  typedef enum logic [1:0] {P_IDLE, P_CHECK, P_PROG, P_ERASE} sspc_port_e;

  sspc_port_e state_r, state_nxt;
  logic rd_r, rd_nxt, prog_r, prog_nxt, erase_r, erase_nxt, ee_r, ee_nxt;
  logic [13:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [18:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt, refused_r, refused_nxt, tmo_r, tmo_nxt;

  // the array is only touched after a successful launch, so an abort never reaches here
  always_comb begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    prog_nxt = prog_r;
    erase_nxt = erase_r;
    ee_nxt = ee_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    cnt_nxt = cnt_r + 19'd1;
    done_nxt = 1'b0;
    refused_nxt = 1'b0;
    tmo_nxt = 1'b0;
    case (state_r)
      P_IDLE: begin
        cnt_nxt = 19'd0;
        if (op.start) begin
          ee_nxt = op.ee_sel;
          addr_nxt = op.addr;
          wdata_nxt = op.wdata;
          if (op.erase) begin
            erase_nxt = 1'b1;
            state_nxt = P_ERASE;
          end else begin
            rd_nxt = 1'b1; // blank check before programming
            state_nxt = P_CHECK;
          end
        end
      end
      P_CHECK: begin
        if (fl_ack_i) begin
          rd_nxt = 1'b0;
          cnt_nxt = 19'd0;
          if (fl_rdata_i == sspc_pkg::BLANK_BYTE) begin
            prog_nxt = 1'b1;
            state_nxt = P_PROG;
          end else begin
            refused_nxt = 1'b1; // byte already programmed
            done_nxt = 1'b1;
            state_nxt = P_IDLE;
          end
        end else if (cnt_r == PROG_CYC) begin
          rd_nxt = 1'b0;
          tmo_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = P_IDLE;
        end
      end
      P_PROG: begin
        if (fl_ack_i || cnt_r == PROG_CYC) begin
          prog_nxt = 1'b0;
          tmo_nxt = !fl_ack_i;
          done_nxt = 1'b1;
          state_nxt = P_IDLE;
        end
      end
      default: begin
        if (fl_ack_i || cnt_r == ERASE_CYC) begin
          erase_nxt = 1'b0;
          tmo_nxt = !fl_ack_i;
          done_nxt = 1'b1;
          state_nxt = P_IDLE;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= P_IDLE;
      rd_r <= 1'b0;
      prog_r <= 1'b0;
      erase_r <= 1'b0;
      ee_r <= 1'b0;
      addr_r <= 14'h0000;
      wdata_r <= 8'h00;
      cnt_r <= 19'h00000;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      tmo_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      prog_r <= prog_nxt;
      erase_r <= erase_nxt;
      ee_r <= ee_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      refused_r <= refused_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  assign fl_rd_o = rd_r;
  assign fl_prog_o = prog_r;
  assign fl_erase_o = erase_r;
  assign fl_ee_sel_o = ee_r; // sector size follows the array
  assign fl_addr_o = addr_r;
  assign fl_wdata_o = wdata_r;
  assign op.done = done_r;
  assign op.refused = refused_r;
  assign op.timeout = tmo_r;

endmodule : sspc_flash_port

// ==== hw/sspc_ctrl.sv ====
// sspc_ctrl: top of the self sector programming controller on the cpu register bus
//
// Summary of operation
// - first key write must carry 5 in the low nibble, else abort.
// - second key write must carry 0xa, else the pending operation aborts.
// - third key write must carry 0x9, else the pending operation aborts.
// - fourth key write must carry 0x6, else the pending operation aborts.
// - a byte program holds the cpu idle until programming ends.
// - a sector erase holds the cpu idle until the erase ends.
// - array select bit steers code reads and operations; one means eeprom array.
// - erase covers one sector: 256 bytes eeprom, 1024 bytes main.
// - type 0xe6 erases a sector, 0x6e programs a byte, others nothing.
// - main memory page bits 5..2 give sector, bits 1..0 high address.
// - offset register gives the low eight address bits in the sector.
// - a programmed byte cannot be programmed again before sector erase.
`timescale 1ns/1ns
module sspc_ctrl #(
  parameter logic [18:0] ERASE_TIMEOUT_CYC = 19'(sspc_pkg::ERASE_MAX_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic cpu_idle_o,
  output logic ssp_done_o,
  output logic ssp_abort_o,
  output logic ssp_refused_o,
  output logic ssp_timeout_o,
  output logic code_ee_sel_o,
  output logic fl_rd_o,
  output logic fl_prog_o,
  output logic fl_erase_o,
  output logic fl_ee_sel_o,
  output logic [13:0] fl_addr_o,
  output logic [7:0] fl_wdata_o,
  input wire logic [7:0] fl_rdata_i,
  input wire logic fl_ack_i
);

  typedef enum logic [1:0] {S_IDLE, S_KEYS, S_SETTLE, S_RUN} sspc_seq_e;

  // map a bus address onto a register, used by the write and the read path
  function automatic sspc_pkg::sspc_reg_e sspc_decode(input logic [7:0] a);
    if (a == sspc_pkg::ADDR_ARRAY_SEL) begin
      return sspc_pkg::REG_ARRAY_SEL;
    end else if (a == sspc_pkg::ADDR_TYPE) begin
      return sspc_pkg::REG_TYPE;
    end else if (a == sspc_pkg::ADDR_KEY1) begin
      return sspc_pkg::REG_KEY1;
    end else if (a == sspc_pkg::ADDR_KEY2) begin
      return sspc_pkg::REG_KEY2;
    end else if (a == sspc_pkg::ADDR_KEY3) begin
      return sspc_pkg::REG_KEY3;
    end else if (a == sspc_pkg::ADDR_KEY4) begin
      return sspc_pkg::REG_KEY4;
    end else if (a == sspc_pkg::ADDR_PAGE) begin
      return sspc_pkg::REG_PAGE;
    end else if (a == sspc_pkg::ADDR_OFFSET) begin
      return sspc_pkg::REG_OFFSET;
    end else if (a == sspc_pkg::ADDR_DATA) begin
      return sspc_pkg::REG_DATA;
    end else begin
      return sspc_pkg::REG_NONE;
    end
  endfunction : sspc_decode

  // expected nibble for key position 0..3
  function automatic logic [3:0] sspc_key_val(input logic [1:0] k);
    case (k)
      2'd0: return sspc_pkg::KEY1_VAL;
      2'd1: return sspc_pkg::KEY2_VAL;
      2'd2: return sspc_pkg::KEY3_VAL;
      default: return sspc_pkg::KEY4_VAL;
    endcase
  endfunction : sspc_key_val

  // a type code that launches something
  function automatic logic sspc_type_ok(input logic [7:0] t);
    return (t == sspc_pkg::TYPE_ERASE) || (t == sspc_pkg::TYPE_PROG);
  endfunction : sspc_type_ok

  sspc_op_if op_if ();

  sspc_pkg::sspc_reg_e hit;
  logic wr_ok;

  // register file
  logic [5:0] page_r, page_nxt;
  logic [7:0] offset_r, offset_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] type_r, type_nxt;
  logic [3:0] key_r [sspc_pkg::NUM_KEYS];
  logic [3:0] key_nxt [sspc_pkg::NUM_KEYS];
  logic sel_r, sel_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // sequencer
  sspc_seq_e seq_r, seq_nxt;
  logic [1:0] kidx_r, kidx_nxt;
  logic [2:0] settle_r, settle_nxt;
  logic idle_r, idle_nxt;
  logic start_r, start_nxt;
  logic erase_r, erase_nxt;
  logic ee_r, ee_nxt;
  logic [13:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt, abort_r, abort_nxt, refused_r, refused_nxt, tmo_r, tmo_nxt;

  assign hit = sspc_decode(sfr_addr_i);
  // the cpu is parked while the array works, so writes then are stray and dropped
  assign wr_ok = sfr_wr_i && (seq_r != S_RUN) && (seq_r != S_SETTLE);

  // register writes; reserved bits are not stored and read back as zero
  always_comb begin
    page_nxt = page_r;
    offset_nxt = offset_r;
    data_nxt = data_r;
    type_nxt = type_r;
    sel_nxt = sel_r;
    if (wr_ok) begin
      if (hit == sspc_pkg::REG_PAGE) begin
        page_nxt = sfr_wdata_i[5:0];
      end else if (hit == sspc_pkg::REG_OFFSET) begin
        offset_nxt = sfr_wdata_i;
      end else if (hit == sspc_pkg::REG_DATA) begin
        data_nxt = sfr_wdata_i;
      end else if (hit == sspc_pkg::REG_TYPE) begin
        type_nxt = sfr_wdata_i;
      end else if (hit == sspc_pkg::REG_ARRAY_SEL) begin
        sel_nxt = sfr_wdata_i[sspc_pkg::ARRAY_SEL_POS];
      end
    end
  end

  // one key register per position
  for (genvar g = 0; g < sspc_pkg::NUM_KEYS; g++) begin : g_key
    always_comb begin
      key_nxt[g] = key_r[g];
      if (wr_ok && hit == sspc_pkg::sspc_reg_e'(int'(sspc_pkg::REG_KEY1) + g)) begin
        key_nxt[g] = sfr_wdata_i[3:0];
      end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        key_r[g] <= sspc_pkg::RST_KEY;
      end else begin
        key_r[g] <= key_nxt[g];
      end
    end
  end

  // read path, registered; unmapped addresses return zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd_i) begin
      case (hit)
        sspc_pkg::REG_ARRAY_SEL: rdata_nxt = {7'h00, sel_r};
        sspc_pkg::REG_TYPE: rdata_nxt = type_r;
        sspc_pkg::REG_KEY1: rdata_nxt = {4'h0, key_r[0]};
        sspc_pkg::REG_KEY2: rdata_nxt = {4'h0, key_r[1]};
        sspc_pkg::REG_KEY3: rdata_nxt = {4'h0, key_r[2]};
        sspc_pkg::REG_KEY4: rdata_nxt = {4'h0, key_r[3]};
        sspc_pkg::REG_PAGE: rdata_nxt = {2'h0, page_r};
        sspc_pkg::REG_OFFSET: rdata_nxt = offset_r;
        sspc_pkg::REG_DATA: rdata_nxt = data_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // key sequencer: any write other than the expected key kills the attempt
  always_comb begin
    seq_nxt = seq_r;
    kidx_nxt = kidx_r;
    settle_nxt = settle_r;
    idle_nxt = idle_r;
    start_nxt = 1'b0;
    erase_nxt = erase_r;
    ee_nxt = ee_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    abort_nxt = 1'b0;
    refused_nxt = 1'b0;
    tmo_nxt = 1'b0;
    case (seq_r)
      S_IDLE: begin
        kidx_nxt = 2'd0;
        if (wr_ok && hit == sspc_pkg::REG_TYPE && sspc_type_ok(sfr_wdata_i)) begin
          seq_nxt = S_KEYS;
        end
      end
      S_KEYS: begin
        if (wr_ok) begin
          if (hit == sspc_pkg::sspc_reg_e'(int'(sspc_pkg::REG_KEY1) + int'(kidx_r)) &&
              sfr_wdata_i[3:0] == sspc_key_val(kidx_r)) begin
            kidx_nxt = kidx_r + 2'd1;
            if (kidx_r == 2'd3) begin
              seq_nxt = S_SETTLE;
              settle_nxt = 3'd0;
              idle_nxt = 1'b1; // park the cpu from launch on
            end
          end else begin
            abort_nxt = 1'b1; // nothing was sent to the array
            kidx_nxt = 2'd0;
            if (hit == sspc_pkg::REG_TYPE && sspc_type_ok(sfr_wdata_i)) begin
              seq_nxt = S_KEYS; // a fresh type write restarts
            end else begin
              seq_nxt = S_IDLE;
            end
          end
        end
      end
      S_SETTLE: begin
        // short pause so the parked cpu has drained before the array starts
        settle_nxt = settle_r + 3'd1;
        if (settle_r == 3'(sspc_pkg::SETTLE_CYC - 1)) begin
          start_nxt = 1'b1;
          erase_nxt = (type_r == sspc_pkg::TYPE_ERASE);
          ee_nxt = sel_r;
          wdata_nxt = data_r;
          seq_nxt = S_RUN;
          if (type_r == sspc_pkg::TYPE_ERASE) begin
            // sector base of the selected array
            if (sel_r) begin
              addr_nxt = {sspc_pkg::EE_ADDR_PAD,
                          page_r[sspc_pkg::HIGH_ADDR_MSB:0], sspc_pkg::EE_SECT_BASE};
            end else begin
              addr_nxt = {page_r[sspc_pkg::MAIN_SECT_MSB:sspc_pkg::MAIN_SECT_LSB],
                          sspc_pkg::MAIN_SECT_BASE};
            end
          end else if (sel_r) begin
            addr_nxt = {sspc_pkg::EE_ADDR_PAD, page_r[sspc_pkg::HIGH_ADDR_MSB:0],
                        offset_r};
          end else begin
            addr_nxt = {page_r, offset_r};
          end
        end
      end
      default: begin
        if (op_if.done) begin
          idle_nxt = 1'b0; // cpu resumes
          done_nxt = 1'b1;
          refused_nxt = op_if.refused;
          tmo_nxt = op_if.timeout;
          seq_nxt = S_IDLE;
        end
      end
    endcase
  end

  // registers of the bus side and sequencer
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      page_r <= sspc_pkg::RST_PAGE;
      offset_r <= sspc_pkg::RST_BYTE;
      data_r <= sspc_pkg::RST_BYTE;
      type_r <= sspc_pkg::RST_BYTE;
      sel_r <= sspc_pkg::RST_ARRAY_SEL;
      rdata_r <= sspc_pkg::RST_BYTE;
      seq_r <= S_IDLE;
      kidx_r <= 2'd0;
      settle_r <= 3'd0;
      idle_r <= 1'b0;
      start_r <= 1'b0;
      erase_r <= 1'b0;
      ee_r <= 1'b0;
      addr_r <= 14'h0000;
      wdata_r <= 8'h00;
      done_r <= 1'b0;
      abort_r <= 1'b0;
      refused_r <= 1'b0;
      tmo_r <= 1'b0;
    end else begin
      page_r <= page_nxt;
      offset_r <= offset_nxt;
      data_r <= data_nxt;
      type_r <= type_nxt;
      sel_r <= sel_nxt;
      rdata_r <= rdata_nxt;
      seq_r <= seq_nxt;
      kidx_r <= kidx_nxt;
      settle_r <= settle_nxt;
      idle_r <= idle_nxt;
      start_r <= start_nxt;
      erase_r <= erase_nxt;
      ee_r <= ee_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      abort_r <= abort_nxt;
      refused_r <= refused_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  assign op_if.start = start_r;
  assign op_if.erase = erase_r;
  assign op_if.ee_sel = ee_r;
  assign op_if.addr = addr_r;
  assign op_if.wdata = wdata_r;

  // flash array driver
  sspc_flash_port #(
    .ERASE_CYC(ERASE_TIMEOUT_CYC),
    .PROG_CYC(19'(sspc_pkg::PROG_MAX_CYC))
  ) u_port (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .op(op_if.port),
    .fl_rd_o(fl_rd_o),
    .fl_prog_o(fl_prog_o),
    .fl_erase_o(fl_erase_o),
    .fl_ee_sel_o(fl_ee_sel_o),
    .fl_addr_o(fl_addr_o),
    .fl_wdata_o(fl_wdata_o),
    .fl_rdata_i(fl_rdata_i),
    .fl_ack_i(fl_ack_i)
  );

  assign sfr_rdata_o = rdata_r;
  assign cpu_idle_o = idle_r;
  assign ssp_done_o = done_r;
  assign ssp_abort_o = abort_r;
  assign ssp_refused_o = refused_r;
  assign ssp_timeout_o = tmo_r;
  assign code_ee_sel_o = sel_r; // code space reads follow the same bit

endmodule : sspc_ctrl

// ==== dv/sspc_flash_model.sv ====
// sspc_flash_model: behavioural main and eeprom array behind the controller
`timescale 1ns/1ns
module sspc_flash_model (
  input wire logic clk_sys_i,
  input wire logic rd_i,
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic ee_i,
  input wire logic [13:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic mute_i,
  input wire logic [7:0] dly_i,
  output logic [7:0] rdata_o,
  output logic ack_o
);
  logic [7:0] mem [logic [14:0]];
  initial begin
    ack_o = 1'b0;
    rdata_o = 8'h00;
  end
  // one request at a time; read data wanders outside the ack cycle
  always begin
    @(posedge clk_sys_i);
    #1;
    ack_o = 1'b0;
    rdata_o = rdata_o + 8'h35;
    if ((rd_i || prog_i || erase_i) && !mute_i) begin
      repeat (dly_i) @(posedge clk_sys_i);
      #1;
      if (rd_i) begin
        rdata_o = mem.exists({ee_i, addr_i}) ? mem[{ee_i, addr_i}] : 8'hff;
      end else if (prog_i) begin
        // bits only fall, so a second program cannot restore ones
        mem[{ee_i, addr_i}] = wdata_i &
          (mem.exists({ee_i, addr_i}) ? mem[{ee_i, addr_i}] : 8'hff);
      end else begin
        for (int i = 0; i < (ee_i ? 256 : 1024); i++) begin
          mem.delete({ee_i, addr_i + 14'(i)});
        end
      end
      ack_o = 1'b1;
    end
  end
endmodule : sspc_flash_model

// ==== dv/sspc_ctrl_properties.sv ====
// sspc_ctrl_properties: port level checks of the controller
`timescale 1ns/1ns
module sspc_ctrl_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic cpu_idle_o,
  input wire logic ssp_done_o,
  input wire logic ssp_abort_o,
  input wire logic ssp_refused_o,
  input wire logic code_ee_sel_o,
  input wire logic fl_rd_o,
  input wire logic fl_prog_o,
  input wire logic fl_erase_o,
  input wire logic fl_ee_sel_o,
  input wire logic [13:0] fl_addr_o,
  input wire logic [7:0] fl_rdata_i,
  input wire logic fl_ack_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // launch steps: valid type while free, then the keys in ascending order
  sequence arm_s;
    !cpu_idle_o && sfr_wr_i && sfr_addr_i == 8'hf2 && sfr_wdata_i inside {8'he6, 8'h6e};
  endsequence
  sequence key_s(a, n);
    sfr_wr_i && sfr_addr_i == a && sfr_wdata_i[3:0] == n;
  endsequence
  sequence three_s;
    arm_s ##1 key_s(8'hf3, 4'h5) ##1 key_s(8'hf4, 4'ha) ##1 key_s(8'hf5, 4'h9);
  endsequence
  sequence keys_s;
    three_s ##1 key_s(8'hf6, 4'h6);
  endsequence
  launch_idle_a: assert property (keys_s |=> cpu_idle_o)
    else $error("cpu not idled after keys");
  launch_req_a: assert property (keys_s |-> ##6 (fl_rd_o || fl_erase_o))
    else $error("array request late");
  bad_first_a: assert property (arm_s ##1 (sfr_wr_i && !(sfr_addr_i == 8'hf3 &&
    sfr_wdata_i[3:0] == 4'h5)) |=> ssp_abort_o) else $error("no abort on first key");
  bad_last_a: assert property (three_s ##1 (sfr_wr_i && sfr_addr_i == 8'hf6 &&
    sfr_wdata_i[3:0] != 4'h6) |=> ssp_abort_o && !cpu_idle_o) else $error("no abort on key four");
  abort_quiet_a: assert property (ssp_abort_o |->
    (!(fl_rd_o || fl_prog_o || fl_erase_o))[*8])
    else $error("array touched after abort");
  erase_base_a: assert property ($rose(fl_erase_o) |-> (fl_ee_sel_o ?
    (fl_addr_o[13:10] == 4'h0 && fl_addr_o[7:0] == 8'h00) : fl_addr_o[9:0] == 10'h000))
    else $error("erase not at sector base");
  blank_prog_a: assert property (fl_rd_o && fl_ack_i && fl_rdata_i == 8'hff
    |=> fl_prog_o && !fl_rd_o) else $error("blank byte not programmed");
  used_refuse_a: assert property (fl_rd_o && fl_ack_i && fl_rdata_i != 8'hff
    |=> !fl_prog_o ##1 (ssp_done_o && ssp_refused_o)) else $error("used byte not refused");
  busy_idle_a: assert property (fl_rd_o || fl_prog_o || fl_erase_o |-> cpu_idle_o)
    else $error("cpu running during operation");
  done_free_a: assert property ($rose(ssp_done_o) |-> $fell(cpu_idle_o))
    else $error("idle not released at done");
  target_sel_a: assert property ($rose(fl_rd_o || fl_erase_o) |->
    fl_ee_sel_o == code_ee_sel_o) else $error("array target differs from select");
  sel_write_a: assert property (sfr_wr_i && sfr_addr_i == 8'ha7 && !cpu_idle_o
    |=> code_ee_sel_o == $past(sfr_wdata_i[0])) else $error("select bit not taken");
endmodule : sspc_ctrl_properties

bind sspc_ctrl sspc_ctrl_properties u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
  .cpu_idle_o(cpu_idle_o), .ssp_done_o(ssp_done_o), .ssp_abort_o(ssp_abort_o),
  .ssp_refused_o(ssp_refused_o), .code_ee_sel_o(code_ee_sel_o), .fl_rd_o(fl_rd_o),
  .fl_prog_o(fl_prog_o), .fl_erase_o(fl_erase_o), .fl_ee_sel_o(fl_ee_sel_o),
  .fl_addr_o(fl_addr_o), .fl_rdata_i(fl_rdata_i), .fl_ack_i(fl_ack_i));

// ==== dv/tb_sspc_ctrl.sv ====
// tb_sspc_ctrl: self checking bench of the self sector programming controller
`timescale 1ns/1ns
module tb_sspc_ctrl;
  logic clk_sys_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, mute = 0, sel = 0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, dly = 8'h02, sfr_rdata_o;
  logic [7:0] fl_wdata_o, fl_rdata_i, cap_data, p, o, d;
  logic [13:0] fl_addr_o, cap_addr;
  logic cpu_idle_o, ssp_done_o, ssp_abort_o, ssp_refused_o, ssp_timeout_o, code_ee_sel_o;
  logic fl_rd_o, fl_prog_o, fl_erase_o, fl_ee_sel_o, fl_ack_i;
  logic got_done, got_abort, got_ref, got_tmo, got_prog;
  int n_mismatch = 0, checked = 0;
  logic [31:0] rs = 32'd70218;
  logic [7:0] ref_mem [logic [14:0]];
  logic [7:0] ra [10] = '{8'ha7, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hfb, 8'hfc, 8'h80};
  logic [7:0] rm [10] = '{8'h01, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'h00};
  logic [3:0] kv [5] = '{4'h0, 4'h5, 4'ha, 4'h9, 4'h6};

  sspc_ctrl #(.ERASE_TIMEOUT_CYC(19'd200)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .cpu_idle_o(cpu_idle_o), .ssp_done_o(ssp_done_o),
    .ssp_abort_o(ssp_abort_o), .ssp_refused_o(ssp_refused_o), .ssp_timeout_o(ssp_timeout_o),
    .code_ee_sel_o(code_ee_sel_o), .fl_rd_o(fl_rd_o), .fl_prog_o(fl_prog_o),
    .fl_erase_o(fl_erase_o), .fl_ee_sel_o(fl_ee_sel_o), .fl_addr_o(fl_addr_o),
    .fl_wdata_o(fl_wdata_o), .fl_rdata_i(fl_rdata_i), .fl_ack_i(fl_ack_i));
  sspc_flash_model u_flash (.clk_sys_i(clk_sys_i), .rd_i(fl_rd_o), .prog_i(fl_prog_o),
    .erase_i(fl_erase_o), .ee_i(fl_ee_sel_o), .addr_i(fl_addr_o), .wdata_i(fl_wdata_o),
    .mute_i(mute), .dly_i(dly), .rdata_o(fl_rdata_i), .ack_o(fl_ack_i));

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // status pulses stand one cycle, so they are latched here
  always @(posedge clk_sys_i) begin
    if (ssp_done_o === 1'b1) begin
      got_done <= 1'b1;
      got_ref <= ssp_refused_o;
      got_tmo <= ssp_timeout_o;
    end
    if (ssp_abort_o === 1'b1) got_abort <= 1'b1;
    if (fl_prog_o === 1'b1) got_prog <= 1'b1;
    if (fl_prog_o === 1'b1 || fl_erase_o === 1'b1) cap_addr <= fl_addr_o;
    if (fl_prog_o === 1'b1) cap_data <= fl_wdata_o;
  end

  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chkv
  task automatic chkf(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkf
  // each access waits an edge first, so strobes never toggle twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    #1;
    sfr_wr_i = 1'b1;
    sfr_addr_i = a;
    sfr_wdata_i = v;
    @(posedge clk_sys_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    #1;
    sfr_rd_i = 1'b1;
    sfr_addr_i = a;
    @(posedge clk_sys_i);
    #1;
    sfr_rd_i = 1'b0;
    chkv(16'(sfr_rdata_o), 16'(exp));
  endtask : rd
  // type then four keys back to back; bad spoils one key, high nibbles random
  task automatic launch(input logic [7:0] typ, input int bad, input int lim);
    logic [7:0] r;
    {got_done, got_abort, got_ref, got_tmo, got_prog} = 5'h00;
    @(posedge clk_sys_i);
    #1;
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      sfr_wr_i = 1'b1;
      sfr_addr_i = 8'hf2 + 8'(i);
      sfr_wdata_i = (i == 0) ? typ : {r[7:4], kv[i] ^ ((i == bad) ? 4'h3 : 4'h0)};
      @(posedge clk_sys_i);
      #1;
    end
    sfr_wr_i = 1'b0; // bus stays quiet after the keys
    for (int n = 0; n < lim && !got_done && !got_abort; n++) @(posedge clk_sys_i);
    #1;
  endtask : launch
  task automatic prog(input logic [7:0] pg, input logic [7:0] off, input logic [7:0] dat);
    logic [13:0] a;
    logic blank;
    a = sel ? {4'h0, pg[1:0], off} : {pg[5:0], off};
    blank = !ref_mem.exists({sel, a}) || ref_mem[{sel, a}] === 8'hff;
    wr(8'hf7, pg);
    wr(8'hfb, off);
    wr(8'hfc, dat);
    launch(8'h6e, 0, 8000);
    chkf(got_done, 1'b1);
    chkf(got_ref, !blank);
    if (blank) begin
      chkv(16'(cap_addr), 16'(a));
      chkv(16'(cap_data), 16'(dat));
      ref_mem[{sel, a}] = dat;
    end
  endtask : prog
  task automatic erase(input logic [7:0] pg);
    logic [13:0] b;
    b = sel ? {4'h0, pg[1:0], 8'h00} : {pg[5:2], 10'h000};
    wr(8'hf7, pg);
    launch(8'he6, 0, 8000);
    chkf(got_done, 1'b1);
    chkf(got_tmo, mute);
    chkv(16'(cap_addr), 16'(b));
    for (int i = 0; i < (sel ? 256 : 1024) && !mute; i++) ref_mem.delete({sel, b + 14'(i)});
  endtask : erase
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // watchdog well beyond the longest expected run
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++) rd(ra[i], 8'h00);
    for (int i = 0; i < 10; i++) begin
      d = rnd();
      wr(ra[i], d);
      rd(ra[i], d & rm[i]);
    end
    wr(8'ha7, 8'h00);
    p = rnd() & 8'h3f;
    o = rnd();
    d = rnd() & 8'hfe;
    prog(p, o, d);
    prog(p, o, ~d);
    erase(p);
    prog(p, o, ~d);
    for (int b = 1; b <= 4; b++) begin
      launch(8'h6e, b, 20);
      chkf(got_abort, 1'b1);
      chkf(got_prog, 1'b0);
    end
    launch(8'h55, 0, 40);
    chkf(got_done | got_abort, 1'b0);
    wr(8'ha7, 8'h01);
    sel = 1'b1;
    dly = 8'h20;
    prog(p, o, d);
    erase(p);
    mute = 1'b1;
    erase(p);
    mute = 1'b0;
    wr(8'ha7, 8'h00);
    sel = 1'b0;
    chkf(code_ee_sel_o, 1'b0);
    wr(8'hf7, 8'h00);
    rd(8'hf7, 8'h00);
    summarize();
  end
endmodule : tb_sspc_ctrl
